/* File: event_fifo_debug_peek.v */
// Event FIFO with a non-destructive debug view of its head entry, behind an APB slave.
// Assumes a single 100 MHz clock and an APB master in the same clock domain.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "event_fifo_debug_peek_regs.vh"

module event_fifo_debug_peek #(
   parameter DEPTH_LOG2 = 4
) (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        sys_rst,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr
);

   localparam DEPTH = 1 << DEPTH_LOG2;

   reg  [13:0]           fifo_mem [0:DEPTH-1];
   reg  [DEPTH_LOG2:0]   wr_ptr;
   reg  [DEPTH_LOG2:0]   rd_ptr;
   reg                   overrun;
   reg  [2:0]            buffer_control_two;
   reg  [31:0]           next_prdata;
   reg                   next_pslverr;

   wire                  access;
   wire                  event_queue_vacant_flag;
   wire                  fifo_full;
   wire [13:0]           head_entry;
   wire [3:0]            event_source_channel_field;
   wire [9:0]            event_result_field;
   wire [15:0]           event_fifo_debug_view;
   wire                  buffered_mode;
   wire                  channel_tag_enable;
   wire                  event_byte_format_select;
   wire                  normal_hit;
   wire                  normal_pop;
   wire                  push_hit;

   assign access                   = psel & penable & ~pready;
   assign buffered_mode            = buffer_control_two[`CTRL_BUFFERED_BIT];
   assign channel_tag_enable       = buffer_control_two[`CTRL_CHAN_TAG_BIT];
   assign event_byte_format_select = buffer_control_two[`CTRL_BYTE_FMT_BIT];
   assign event_queue_vacant_flag  = (wr_ptr == rd_ptr);
   assign fifo_full = (wr_ptr[DEPTH_LOG2] != rd_ptr[DEPTH_LOG2]) &&
                      (wr_ptr[DEPTH_LOG2-1:0] == rd_ptr[DEPTH_LOG2-1:0]);

   // The head is addressed by the same pointer that a normal read uses.
   assign head_entry = fifo_mem[rd_ptr[DEPTH_LOG2-1:0]];

   assign event_source_channel_field = channel_tag_enable ?
                                       head_entry[`PUSH_CHAN_HI:`PUSH_CHAN_LO] : 4'h0;

   // Shifting here rather than at push lets software flip the format on stored data.
   assign event_result_field = event_byte_format_select ?
                               {2'h0, head_entry[9:2]} : head_entry[9:0];

   assign event_fifo_debug_view = {event_queue_vacant_flag,
                                   1'b0,
                                   event_source_channel_field,
                                   event_result_field};

   assign normal_hit = (paddr >= `OFS_NORMAL_READ) && (paddr <= `OFS_NORMAL_READ_LAST) &&
                       (paddr[1:0] == 2'h0);
   assign normal_pop = access & ~pwrite & normal_hit & buffered_mode &
                       ~event_queue_vacant_flag & ~overrun;
   assign push_hit   = access & pwrite & (paddr == `OFS_PUSH_WORD) & buffered_mode;

   always @* begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b0;
      if (!pwrite) begin
         if (paddr == `OFS_DEBUG_VIEW) begin
            // Outside buffered mode the view is not present and reads zero.
            if (buffered_mode) begin
               next_prdata = {16'h0000, event_fifo_debug_view};
            end
         end else if (normal_hit) begin
            if (buffered_mode) begin
               next_prdata = {16'h0000, event_fifo_debug_view};
            end
         end else if (paddr == `OFS_BUFFER_CONTROL) begin
            next_prdata = {29'h0000_0000, buffer_control_two};
         end else if (paddr == `OFS_FIFO_STATUS) begin
            next_prdata = {29'h0000_0000, overrun, fifo_full, event_queue_vacant_flag};
         end else if (paddr != `OFS_PUSH_WORD) begin
            next_pslverr = 1'b1;
         end
      end else begin
         // The debug view and normal port are read-only; writes are dropped.
         if ((paddr != `OFS_BUFFER_CONTROL) && (paddr != `OFS_PUSH_WORD) &&
             (paddr != `OFS_DEBUG_VIEW) && !normal_hit) begin
            next_pslverr = 1'b1;
         end
      end
   end

   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= access;
         prdata  <= access ? next_prdata : 32'h0000_0000;
         pslverr <= access ? next_pslverr : 1'b0;
      end
   end

   // Pointers reset equal so the view comes up empty; control resets with tag off, so the channel field reads zero.
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr             <= {(DEPTH_LOG2+1){1'b0}};
         rd_ptr             <= {(DEPTH_LOG2+1){1'b0}};
         overrun            <= 1'b0;
         buffer_control_two <= `CTRL_RESET_VALUE;
      end else begin
         if (access & pwrite & (paddr == `OFS_BUFFER_CONTROL)) begin
            buffer_control_two <= pwdata[2:0];
         end
         if (push_hit & ~fifo_full) begin
            wr_ptr <= wr_ptr + {{DEPTH_LOG2{1'b0}}, 1'b1};
         end
         // Overrun is sticky until buffered mode is left; a push on full sets it.
         if (push_hit & fifo_full) begin
            overrun <= 1'b1;
         end else if (!buffered_mode) begin
            overrun <= 1'b0;
         end
         // Only the normal port pops; a debug view read never touches rd_ptr.
         if (normal_pop) begin
            rd_ptr <= rd_ptr + {{DEPTH_LOG2{1'b0}}, 1'b1};
         end
      end
   end

   // Storage has no reset, so the result field is undefined after reset.
   always @(posedge ref_clk) begin
      if (push_hit & ~fifo_full) begin
         fifo_mem[wr_ptr[DEPTH_LOG2-1:0]] <= pwdata[13:0];
      end
   end

endmodule // event_fifo_debug_peek

/* File: event_fifo_debug_peek_regs.vh */
// Register offsets, field positions and reset values for the event FIFO debug view block.
// Assumes inclusion by bare name from the design file; holds definitions only.
`ifndef EVENT_FIFO_DEBUG_PEEK_REGS_VH
`define EVENT_FIFO_DEBUG_PEEK_REGS_VH

// Byte offsets on the APB.
`define OFS_DEBUG_VIEW        8'h90
`define OFS_NORMAL_READ       8'h20
`define OFS_NORMAL_READ_LAST  8'h3C
`define OFS_BUFFER_CONTROL    8'hA0
`define OFS_PUSH_WORD         8'hA4
`define OFS_FIFO_STATUS       8'hA8

// Debug view field positions.
`define VIEW_VACANT_BIT       15
`define VIEW_RSVD_BIT         14
`define VIEW_CHAN_HI          13
`define VIEW_CHAN_LO          10
`define VIEW_RESULT_HI        9
`define VIEW_RESULT_LO        0

// Buffer control fields.
`define CTRL_BUFFERED_BIT     0
`define CTRL_CHAN_TAG_BIT     1
`define CTRL_BYTE_FMT_BIT     2
`define CTRL_RESET_VALUE      3'h0

// Push word fields: channel in 13..10, result in 9..0.
`define PUSH_CHAN_HI          13
`define PUSH_CHAN_LO          10

`endif

/* File: event_fifo_debug_peek_assertions.sv */
// Checker for the event FIFO debug view block, watching its APB ports only.
// Assumes the single clock and reset of the block and a two-cycle APB access.
`timescale 1ns/1ps
module event_fifo_debug_peek_assertions #(parameter DEPTH_LOG2 = 4) (
   input wire        ref_clk,
   input wire        sys_rst,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   reg [2:0] ctl;
   wire      vrd = pready & psel & !pwrite & (paddr == 8'h90);
   // Shadow of the control register so view reads can be judged against the mode bits.
   always @(posedge ref_clk or posedge sys_rst)
      if (sys_rst) ctl <= 3'h0;
      else if (psel & penable & !pready & pwrite & (paddr == 8'hA0)) ctl <= pwdata[2:0];
   AST_READY: assert property (psel & penable & !pready |=> pready)
      else $error("pready late");
   AST_PULSE: assert property (pready |=> !pready) else $error("pready held");
   AST_RSVD: assert property (vrd |-> prdata[31:14] == 18'h0 || prdata[31:14] == 18'h2)
      else $error("reserved bits set");
   AST_NOERR: assert property (vrd |-> !pslverr) else $error("view read error");
   AST_MODE: assert property (vrd & !ctl[0] |-> prdata == 32'h0) else $error("view outside mode");
   AST_TAG: assert property (vrd & !ctl[1] |-> prdata[13:10] == 4'h0) else $error("tag leak");
   AST_BYTE: assert property (vrd & ctl[2] |-> prdata[9:8] == 2'h0) else $error("byte upper");
   AST_IDLE: assert property (!pready |-> prdata == 32'h0) else $error("data outside answer");
endmodule // event_fifo_debug_peek_assertions
bind event_fifo_debug_peek event_fifo_debug_peek_assertions #(.DEPTH_LOG2(DEPTH_LOG2)) chk_i (.*);

/* File: tb_top.sv */
// Self-checking bench for the event FIFO debug view block.
// Assumes the block answers each APB access after the master holds it, and one 100 MHz clock.
`timescale 1ns/1ps
module tb_top;
   logic        ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic        pready, pslverr, e;
   int          bad_count = 0, n_compared = 0;
   event_fifo_debug_peek DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   initial forever #5 ref_clk = ~ref_clk;
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      begin
         n = 0;
         // The idle edge first keeps a back-to-back call from assigning psel twice in one step.
         @(posedge ref_clk);
         psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
         @(posedge ref_clk);
         penable <= 1;
         do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 50);
         if (pready !== 1'b1) begin
            $display("wrong value pready expected 1 seen %b", pready);
            bad_count++;
         end
         r = prdata; e = pslverr; psel <= 0; penable <= 0;
      end
   endtask
   task chk(input string nm, input logic [31:0] x, g);
      n_compared++;
      if (g !== x) begin
         $display("wrong value %s expected %h seen %h", nm, x, g);
         bad_count++;
      end
   endtask
   task close_out;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task t_idle;
      apb(0, 8'h90, 0); chk("view off", 32'h0, r);
      apb(1, 8'hA0, 32'h1); apb(0, 8'h90, 0); chk("view reset", 32'h8000, r);
      $display("test idle done");
   endtask
   task t_fields;
      apb(1, 8'hA4, 32'h16A7); apb(0, 8'h90, 0); chk("plain", 32'h02A7, r);
      apb(1, 8'h90, 32'hFFFF); apb(1, 8'hA0, 32'h3); apb(0, 8'h90, 0); chk("tag", 32'h16A7, r);
      apb(1, 8'hA0, 32'h7); apb(0, 8'h90, 0); chk("byte", 32'h14A9, r);
      apb(0, 8'h90, 0); chk("peek again", 32'h14A9, r);
      apb(0, 8'h3C, 0); chk("normal", 32'h14A9, r);
      apb(0, 8'h90, 0); chk("popped", 32'h2, r[15:14]);
      apb(0, 8'h10, 0); chk("unmapped err", 32'h1, e);
      $display("test fields done");
   endtask
   task t_fill;
      logic [31:0] x;
      apb(1, 8'hA0, 32'h3);
      for (int i = 0; i < 16; i++) apb(1, 8'hA4, {18'h0, i[3:0], i[3:0], 6'h2B});
      apb(0, 8'hA8, 0); chk("full status", 32'h2, r);
      apb(1, 8'hA4, 32'h3FF); apb(0, 8'hA8, 0); chk("overrun status", 32'h6, r);
      apb(0, 8'h20, 0); chk("overrun read", 32'h2B, r);
      apb(0, 8'h90, 0); chk("overrun no pop", 32'h2B, r);
      apb(1, 8'hA0, 32'h0); apb(0, 8'h20, 0); chk("normal off", 32'h0, r);
      apb(1, 8'hA0, 32'h3); apb(0, 8'hA8, 0); chk("overrun clear", 32'h2, r);
      for (int i = 0; i < 16; i++) begin
         x = {18'h0, i[3:0], i[3:0], 6'h2B};
         apb(0, 8'h90, 0); chk("fill peek", x, r);
         apb(0, 8'h20 + 8'(4 * (i % 8)), 0); chk("fill pop", x, r);
      end
      apb(0, 8'h90, 0); chk("drained", 32'h1, r[15]);
      $display("test fill done");
   endtask
   initial begin
      #100000;
      bad_count++;
      close_out;
   end
   initial begin
      repeat (12) @(posedge ref_clk);
      sys_rst <= 0;
      t_idle; t_fields; t_fill;
      close_out;
   end
endmodule // tb_top
